// *** design/iesw_pkg.sv ***
// constants and types for the two-wire memory host controller
package iesw_pkg;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 25;
   localparam int SCL_PERIOD_NS = 10000;
   // quarter of a serial clock period, rounded up to whole cycles
   localparam int QTR_CYC = (SCL_PERIOD_NS / 4 + CLK_PERIOD_NS - 1)
                            / CLK_PERIOD_NS;

   // ----------------------------------------------------------------
   // software register map
   // ----------------------------------------------------------------
   localparam int         ADDR_W   = 5;
   localparam logic [4:0] OFS_CTRL = 5'h00;
   localparam logic [4:0] OFS_STAT = 5'h04;
   localparam logic [4:0] OFS_TXD  = 5'h08;
   localparam logic [4:0] OFS_RXD  = 5'h0C;
   localparam int         CTRL_W   = 17;

   // command codes, stages of a transfer
   localparam logic [1:0] CMD_WRITE = 2'h0;
   localparam logic [1:0] CMD_CUR   = 2'h1;
   localparam logic [1:0] CMD_RAND  = 2'h2;
   localparam logic [1:0] CMD_POLL  = 2'h3;
   localparam logic [2:0] STG_ADDR  = 3'h0;
   localparam logic [2:0] STG_WORD  = 3'h1;
   localparam logic [2:0] STG_DATA  = 3'h2;
   localparam logic [2:0] STG_RADDR = 3'h3;
   localparam logic [2:0] STG_RX    = 3'h4;
   localparam logic [3:0] BIT_ACK   = 4'h8;

   // control word: word[16:9] count[8:5] strap[4] block[3:2] cmd[1:0]
   typedef struct packed {
      logic [7:0] word;
      logic [3:0] count;
      logic       strap;
      logic [1:0] blk;
      logic [1:0] cmd;
   } iesw_ctrl_t;
   localparam iesw_ctrl_t CTRL_RST = 17'h00000;

   typedef enum logic [3:0] {
      ST_IDLE  = 4'h1,
      ST_START = 4'h2,
      ST_XBYTE = 4'h4,
      ST_STOP  = 4'h8
   } iesw_state_t;

endpackage

// *** design/iesw_host.sv ***
// two-wire bus master that drives a serial memory from software registers
//
// The address map and the plain strobed port were decided locally.
`timescale 1ns/1ps
// Function
// RULE1: start is data falling while clock high
// RULE2: device ignores bus until a start
// RULE3: stop is data rising while clock high
// RULE4: data changes only while clock low
// RULE5: transmitter releases data for ninth-clock acknowledge
// RULE6: device data output is open drain
// RULE7: master starts transfers and makes the clock
// RULE8: device acknowledges its matching slave address
// RULE9: device acknowledges each written byte
// RULE10: type code, strap bit, two block bits
// RULE11: block bits plus word address pick byte
// RULE12: last address bit: one reads, zero writes
// RULE13: write sends word address, data, then stop
// RULE14: device ignores everything while writing internally
// RULE15: page write carries up to sixteen bytes
// RULE16: device write address wraps inside page
// RULE17: poll with write address until acknowledged
// RULE18: protected upper half refuses first data byte
// RULE19: current read uses last address plus one
// RULE20: random read: dummy write, repeated start, read
// RULE21: master acknowledge continues read, none ends it
// RULE22: read address wraps across whole memory
// RULE23: protect pin leaves reads working
// RULE24: internal write ends within ten milliseconds
// RULE25: device filters and synchronises both lines
// RULE26: block bits sit above word address bits
module iesw_host
   import iesw_pkg::*;
#(
   parameter int         QTR      = QTR_CYC,
   parameter logic [3:0] DEV_TYPE = 4'h5  // arbitrary type code
)(
   input  wire logic              clock,
   input  wire logic              srst,
   input  wire logic              ce,
   input  wire logic [ADDR_W-1:0] addr,
   input  wire logic [31:0]       wdata,
   input  wire logic              wr,
   input  wire logic              rd,
   output logic      [31:0]       rdata,
   output logic                   scl_o,
   input  wire logic              sda_i,
   output logic                   sda_o,
   output logic                   sda_oe_n
);

   // ----------------------------------------------------------------
   // pin synchroniser and quarter-period tick
   // ----------------------------------------------------------------
   logic        sda_s1_ff;
   logic        sda_s2_ff;
   logic [15:0] qcnt_ff;
   logic [15:0] nxt_qcnt;
   logic        tick;

   // two-stage synchroniser on the data pin
   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         sda_s1_ff <= 1'b1;
         sda_s2_ff <= 1'b1;
      end
      else if (ce)
      begin
         sda_s1_ff <= sda_i;
         sda_s2_ff <= sda_s1_ff;
      end
   end

   // free running divider, one tick per quarter bit
   always_comb
   begin
      tick     = (qcnt_ff == 16'(QTR - 1));
      nxt_qcnt = tick ? 16'h0000 : qcnt_ff + 16'h0001;
   end

   always_ff @(posedge clock)
   begin
      if (srst)
         qcnt_ff <= 16'h0000;
      else if (ce)
         qcnt_ff <= nxt_qcnt;
   end

   // ----------------------------------------------------------------
   // sequencer and registers
   // ----------------------------------------------------------------
   iesw_state_t state_ff, nxt_state;
   iesw_ctrl_t  ctrl_ff, nxt_ctrl;
   logic [1:0]  phase_ff, nxt_phase;
   logic [3:0]  bit_ff, nxt_bit;
   logic [2:0]  stage_ff, nxt_stage;
   logic [7:0]  shift_ff, nxt_shift;
   logic [3:0]  left_ff, nxt_left;
   logic        ack_ff, nxt_ack;
   logic [7:0]  txd_ff, nxt_txd;
   logic        tx_full_ff, nxt_tx_full;
   logic [7:0]  rxd_ff, nxt_rxd;
   logic        rx_full_ff, nxt_rx_full;
   logic        nack_ff, nxt_nack;
   logic        scl_ff, nxt_scl;
   logic        oe_n_ff, nxt_oe_n;
   logic [31:0] rdata_ff, nxt_rdata;
   logic        rx;
   logic [7:0]  ld;

   // next state of the bus engine and the software registers
   always_comb
   begin
      nxt_state   = state_ff;
      nxt_ctrl    = ctrl_ff;
      nxt_phase   = phase_ff;
      nxt_bit     = bit_ff;
      nxt_stage   = stage_ff;
      nxt_shift   = shift_ff;
      nxt_left    = left_ff;
      nxt_ack     = ack_ff;
      nxt_txd     = txd_ff;
      nxt_tx_full = tx_full_ff;
      nxt_rxd     = rxd_ff;
      nxt_rx_full = rx_full_ff;
      nxt_nack    = nack_ff;
      nxt_scl     = scl_ff;
      nxt_oe_n    = oe_n_ff;
      nxt_rdata   = 32'h00000000;
      rx          = (stage_ff == STG_RX);
      // byte to send, loaded fresh at the first bit
      case (stage_ff)
         STG_ADDR:  ld = {DEV_TYPE, ctrl_ff.strap, ctrl_ff.blk,
                         ctrl_ff.cmd == CMD_CUR};  // RULE12
         STG_WORD:  ld = ctrl_ff.word;
         STG_DATA:  ld = txd_ff;
         STG_RADDR: ld = {DEV_TYPE, ctrl_ff.strap, ctrl_ff.blk, 1'b1};
         default:   ld = 8'hFF;
      endcase
      if (bit_ff != 4'h0)
         ld = shift_ff;

      // software port: command start, data, read-back
      if (wr && addr == OFS_CTRL && state_ff == ST_IDLE)
      begin
         nxt_ctrl  = iesw_ctrl_t'(wdata[CTRL_W-1:0]);
         nxt_left  = wdata[8:5];  // RULE15
         nxt_nack  = 1'b0;
         nxt_stage = STG_ADDR;
         nxt_phase = 2'h0;
         nxt_state = ST_START;  // RULE7
      end
      if (wr && addr == OFS_TXD)
         nxt_txd = wdata[7:0];
      if (rd && addr == OFS_RXD)
         nxt_rx_full = 1'b0;
      if (rd)
      begin
         case (addr)
            OFS_CTRL: nxt_rdata = {15'h0000, ctrl_ff};
            OFS_STAT: nxt_rdata = {28'h0000000, nack_ff, rx_full_ff,
                                   tx_full_ff, state_ff != ST_IDLE};
            OFS_TXD:  nxt_rdata = {24'h000000, txd_ff};
            OFS_RXD:  nxt_rdata = {24'h000000, rxd_ff};
            default:  nxt_rdata = 32'h00000000;
         endcase
      end

      if (tick)
      begin
         case (state_ff)
            ST_START:
            begin
               nxt_phase = phase_ff + 2'h1;
               case (phase_ff)
                  2'h0: nxt_oe_n = 1'b1;
                  2'h1: nxt_scl = 1'b1;
                  2'h2: nxt_oe_n = 1'b0;  // RULE1
                  default:
                  begin
                     nxt_scl   = 1'b0;
                     nxt_bit   = 4'h0;
                     nxt_state = ST_XBYTE;
                  end
               endcase
            end
            ST_STOP:
            begin
               nxt_phase = phase_ff + 2'h1;
               case (phase_ff)
                  2'h0: nxt_oe_n = 1'b0;
                  2'h1: nxt_scl = 1'b1;
                  2'h2: nxt_oe_n = 1'b1;  // RULE3
                  default: nxt_state = ST_IDLE;
               endcase
            end
            ST_XBYTE:
            begin
               nxt_phase = phase_ff + 2'h1;
               case (phase_ff)
                  // data set up while the clock is low
                  2'h0:
                  begin
                     if (bit_ff == 4'h0 &&
                         ((stage_ff == STG_DATA && !tx_full_ff) ||
                          (rx && rx_full_ff)))
                        nxt_phase = 2'h0;  // hold clock low, wait
                     else if (bit_ff == BIT_ACK)
                     begin
                        nxt_oe_n = rx ? (left_ff == 4'h0) : 1'b1;  // RULE5 RULE21
                        if (rx)
                        begin
                           nxt_rxd     = shift_ff;
                           nxt_rx_full = 1'b1;
                        end
                     end
                     else
                     begin
                        nxt_shift = ld;
                        nxt_oe_n  = rx | ld[7];  // RULE4
                        if (bit_ff == 4'h0 && stage_ff == STG_DATA)
                           nxt_tx_full = 1'b0;
                     end
                  end
                  2'h1: nxt_scl = 1'b1;
                  // sample in the middle of the clock high time
                  2'h2:
                  begin
                     if (bit_ff == BIT_ACK)
                        nxt_ack = !sda_s2_ff;
                     else if (rx)
                        nxt_shift = {shift_ff[6:0], sda_s2_ff};
                  end
                  default:
                  begin
                     nxt_scl = 1'b0;
                     if (bit_ff != BIT_ACK)
                     begin
                        nxt_bit = bit_ff + 4'h1;
                        if (!rx)
                           nxt_shift = {shift_ff[6:0], 1'b0};
                     end
                     else
                     begin
                        nxt_bit = 4'h0;
                        // refused byte, busy poll or protected data
                        if (!rx && !ack_ff)
                        begin
                           nxt_nack  = 1'b1;  // RULE17 RULE18
                           nxt_state = ST_STOP;  // RULE13
                        end
                        else
                        begin
                           case (stage_ff)
                              STG_ADDR:
                                 if (ctrl_ff.cmd == CMD_POLL)
                                    nxt_state = ST_STOP;  // RULE17
                                 else if (ctrl_ff.cmd == CMD_CUR)
                                    nxt_stage = STG_RX;
                                 else
                                    nxt_stage = STG_WORD;
                              STG_WORD:
                                 if (ctrl_ff.cmd == CMD_WRITE)
                                    nxt_stage = STG_DATA;  // RULE13
                                 else
                                 begin
                                    nxt_stage = STG_RADDR;
                                    nxt_state = ST_START;  // RULE20
                                 end
                              STG_RADDR: nxt_stage = STG_RX;
                              default:
                                 if (left_ff == 4'h0)
                                    nxt_state = ST_STOP;  // RULE21
                                 else
                                    nxt_left = left_ff - 4'h1;  // RULE15
                           endcase
                        end
                     end
                  end
               endcase
            end
            default: nxt_phase = 2'h0;
         endcase
      end
      // a fresh software write beats the engine taking the byte
      if (wr && addr == OFS_TXD)
         nxt_tx_full = 1'b1;
   end

   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         state_ff   <= ST_IDLE;
         ctrl_ff    <= CTRL_RST;
         phase_ff   <= 2'h0;
         bit_ff     <= 4'h0;
         stage_ff   <= STG_ADDR;
         shift_ff   <= 8'h00;
         left_ff    <= 4'h0;
         ack_ff     <= 1'b0;
         txd_ff     <= 8'h00;
         tx_full_ff <= 1'b0;
         rxd_ff     <= 8'h00;
         rx_full_ff <= 1'b0;
         nack_ff    <= 1'b0;
         scl_ff     <= 1'b1;
         oe_n_ff    <= 1'b1;
         rdata_ff   <= 32'h00000000;
         sda_o      <= 1'b0;
      end
      else if (ce)
      begin
         state_ff   <= nxt_state;
         ctrl_ff    <= nxt_ctrl;
         phase_ff   <= nxt_phase;
         bit_ff     <= nxt_bit;
         stage_ff   <= nxt_stage;
         shift_ff   <= nxt_shift;
         left_ff    <= nxt_left;
         ack_ff     <= nxt_ack;
         txd_ff     <= nxt_txd;
         tx_full_ff <= nxt_tx_full;
         rxd_ff     <= nxt_rxd;
         rx_full_ff <= nxt_rx_full;
         nack_ff    <= nxt_nack;
         scl_ff     <= nxt_scl;
         oe_n_ff    <= nxt_oe_n;
         rdata_ff   <= nxt_rdata;
         sda_o      <= 1'b0;  // open drain: only ever pulls low
      end
   end

   assign rdata    = rdata_ff;
   assign scl_o    = scl_ff;
   assign sda_oe_n = oe_n_ff;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   localparam int A_QTR = QTR;
   default clocking cb @(posedge clock); endclocking
   default disable iff (srst || !ce);

   sequence s_byte_end;
      state_ff == ST_XBYTE && bit_ff == BIT_ACK && phase_ff == 2'h3
      && tick;
   endsequence

   a_start_fall: assert property ( // RULE1
      $fell(oe_n_ff) && scl_ff |-> $past(state_ff) == ST_START)
      else $error("data pulled low under high clock outside start");
   a_data_stable: assert property ( // RULE4
      $changed(oe_n_ff) && scl_ff && $past(scl_ff)
      |-> $past(state_ff) inside {ST_START, ST_STOP})
      else $error("data moved while clock high");
   a_stop_idle: assert property ( // RULE3
      $rose(oe_n_ff) && scl_ff |-> ##[1:A_QTR] state_ff == ST_IDLE)
      else $error("stop not followed by idle");
   a_ack_release: assert property ( // RULE5
      state_ff == ST_XBYTE && !rx && bit_ff == BIT_ACK
      && phase_ff != 2'h0 |-> oe_n_ff)
      else $error("data not released for acknowledge");
   a_idle_quiet: assert property ( // RULE7
      state_ff == ST_IDLE && $past(state_ff) == ST_IDLE
      |-> scl_ff && oe_n_ff)
      else $error("lines driven while idle");
   a_rw_bit: assert property ( // RULE12
      state_ff == ST_XBYTE && bit_ff == 4'h7 && phase_ff != 2'h0
      && stage_ff == STG_ADDR |-> oe_n_ff == (ctrl_ff.cmd == CMD_CUR))
      else $error("direction bit wrong");
   a_poll_stop: assert property ( // RULE17
      s_byte_end ##0 (stage_ff == STG_ADDR && ctrl_ff.cmd == CMD_POLL)
      |=> state_ff == ST_STOP)
      else $error("poll did not end in stop");
   a_rand_rstart: assert property ( // RULE20
      s_byte_end ##0 (stage_ff == STG_WORD && ctrl_ff.cmd == CMD_RAND
      && ack_ff) |=> state_ff == ST_START && stage_ff == STG_RADDR)
      else $error("random read lacks repeated start");
   a_last_nack: assert property ( // RULE21
      state_ff == ST_XBYTE && rx && bit_ff == BIT_ACK && phase_ff != 2'h0
      |-> oe_n_ff == (left_ff == 4'h0))
      else $error("read acknowledge wrong for position");
   a_nack_stop: assert property ( // RULE13
      s_byte_end ##0 (!rx && !ack_ff) |=> state_ff == ST_STOP && nack_ff)
      else $error("refused byte not ended by stop");

endmodule

// *** bench/iesw_mem_model.sv ***
// behavioural two-wire serial memory standing on the host's far side
`timescale 1ns/1ps
module iesw_mem_model #(
   parameter logic [3:0] DEV_TYPE = 4'h6,   // arbitrary type code
   parameter int         WT_NS    = 100000
)(
   input  wire logic scl,
   input  wire logic sda,
   input  wire logic chip_select_strap,
   input  wire logic wp,
   output logic      pull
);
   logic [7:0]  mem [0:1023];
   logic [7:0]  pbuf [0:15];
   logic [15:0] pv;
   logic [9:0]  ptr;
   logic [7:0]  sh;
   logic [7:0]  dout;
   logic [1:0]  blk;
   logic [2:0]  st;   // 0 idle, 1 addr, 2 word, 3 write, 4 read
   logic [3:0]  bn;
   logic        busy;
   logic        tx;
   logic        first;

   // power-up contents and standby
   initial
   begin
      for (int i = 0; i < 1024; i++)
         mem[i] = 8'(i * 3 + 1);
      {pv, ptr, st, bn, busy, tx, pull} = '0;
   end

   // start and stop on the line levels; stop commits the page
   // ideal line levels in this model, so nothing to filter
   always @(sda)
   begin
      if (scl === 1'h1 && sda === 1'h0 && !busy)
      begin
         st = 3'h1;
         bn = 4'h0;
         tx = 1'h0;
      end
      else if (scl === 1'h1 && sda === 1'h1)
      begin
         st = 3'h0;
         pull = 1'h0;
         for (int i = 0; i < 16; i++)
            if (pv[i])
               mem[{ptr[9:4], 4'(i)}] = pbuf[i];
         if (pv != 16'h0000)
         begin
            busy = 1'h1;
            busy <= #WT_NS 1'h0;
         end
         pv = 16'h0000;
      end
   end

   // sample bits; ninth clock checks the master's acknowledge
   always @(posedge scl)
   begin
      if (st != 3'h0 && bn < 4'h8)
      begin
         sh = {sh[6:0], sda};
         bn = bn + 4'h1;
      end
      else if (st != 3'h0)
      begin
         bn = 4'h0;
         if (tx && sda)
            st = 3'h0;
         if (st == 3'h4)
         begin
            dout = mem[ptr];
            ptr = ptr + 10'h001;
            tx = 1'h1;
         end
      end
   end

   // drive data and acknowledges while the clock is low
   always @(negedge scl)
   begin
      pull = 1'h0;
      if (st == 3'h4 && bn < 4'h8)
         pull = ~dout[3'(7 - bn)];
      else if (bn == 4'h8 && st == 3'h1
               && sh[7:3] == {DEV_TYPE, chip_select_strap})
      begin
         pull = 1'h1;
         if (!sh[0])
            blk = sh[2:1];
         st = sh[0] ? 3'h4 : 3'h2;
      end
      else if (bn == 4'h8 && st == 3'h1)
         st = 3'h0;
      else if (bn == 4'h8 && st == 3'h2)
      begin
         pull = 1'h1;
         ptr = {blk, sh};
         st = 3'h3;
         first = 1'h1;
      end
      else if (bn == 4'h8 && st == 3'h3 && first && wp && ptr[9])
         st = 3'h0;
      else if (bn == 4'h8 && st == 3'h3)
      begin
         pull = 1'h1;
         pbuf[ptr[3:0]] = sh;
         pv[ptr[3:0]] = 1'h1;
         ptr[3:0] = ptr[3:0] + 4'h1;
         first = 1'h0;
      end
   end
endmodule

// *** bench/tb.sv ***
// self-checking bench for the two-wire memory host controller
`timescale 1ns/1ps
module tb
   import iesw_pkg::*;
;
   localparam logic [3:0] TYPE = 4'h6;   // arbitrary type code
   logic              clock;
   logic              srst;
   logic              ce;
   logic              sda_o;
   logic              wr;
   logic              rd;
   logic              wp;
   logic              pull;
   logic              scl_o;
   logic              sda_oe_n;
   logic [ADDR_W-1:0] addr;
   logic [31:0]       wdata;
   logic [31:0]       rdata;
   logic [31:0]       rv;
   logic [7:0]        emem [0:1023];
   int                n_errors;
   int                cmp_count;
   int                nb;
   // open-drain line: host drives sda_o while enabled, model only pulls
   wire               sda_line = (sda_oe_n | sda_o) & ~pull;

   iesw_host #(.QTR(4), .DEV_TYPE(TYPE)) uut (
      .clock(clock), .srst(srst), .ce(ce), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .scl_o(scl_o),
      .sda_i(sda_line), .sda_o(sda_o), .sda_oe_n(sda_oe_n));
   iesw_mem_model #(.DEV_TYPE(TYPE)) mdl (
      .scl(scl_o), .sda(sda_line), .chip_select_strap(1'h1),
      .wp(wp), .pull(pull));

   // ----------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------
   task automatic complete_run;
      if (n_errors == 0 && cmp_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         n_errors++;
         $display("mismatch %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic reg_wr(input logic [4:0] a, input logic [31:0] d);
      @(posedge clock);
      addr <= a;
      wdata <= d;
      wr <= 1'h1;
      @(posedge clock);
      wr <= 1'h0;
   endtask

   task automatic reg_rd(input logic [4:0] a);
      @(posedge clock);
      addr <= a;
      rd <= 1'h1;
      @(posedge clock);
      rd <= 1'h0;
      #1 rv = rdata;
   endtask

   // bounded wait on status bits
   task automatic wait_st(input logic [3:0] m, input logic [3:0] v);
      for (int k = 0; k < 5000; k++)
      begin
         reg_rd(OFS_STAT);
         if ((rv[3:0] & m) === v)
            return;
      end
      n_errors++;
      $display("mismatch %0t status wait ran out", $time);
      complete_run();
   endtask

   function automatic logic [31:0] ctl(logic [1:0] c, logic [9:0] a,
                                       int n, logic s);
      iesw_ctrl_t x;
      x = '{word: a[7:0], count: 4'(n - 1), strap: s, blk: a[9:8], cmd: c};
      return {15'h0000, x};
   endfunction

   // write n bytes d0, d0+1, ... starting at a; the caller updates emem
   task automatic do_wr(input logic [9:0] a, input int n,
                        input logic [7:0] d0, input logic s);
      reg_wr(OFS_TXD, {24'h000000, d0});
      reg_wr(OFS_CTRL, ctl(CMD_WRITE, a, n, s));
      for (int i = 1; i < n; i++)
      begin
         wait_st(4'h2, 4'h0);
         reg_wr(OFS_TXD, {24'h000000, d0 + 8'(i)});
      end
      wait_st(4'h1, 4'h0);
   endtask

   // read n bytes and compare with the expected image
   task automatic rd_chk(input logic [1:0] c, input logic [9:0] a,
                         input int n);
      reg_wr(OFS_CTRL, ctl(c, a, n, 1'h1));
      for (int i = 0; i < n; i++)
      begin
         wait_st(4'h4, 4'h4);
         reg_rd(OFS_RXD);
         chk(rv, {24'h000000, emem[10'(a + 10'(i))]});
      end
      wait_st(4'h1, 4'h0);
   endtask

   // poll until acknowledged, counting refusals
   task automatic poll;
      nb = 0;
      for (int k = 0; k < 300; k++)
      begin
         reg_wr(OFS_CTRL, ctl(CMD_POLL, 10'h000, 1, 1'h1));
         wait_st(4'h1, 4'h0);
         reg_rd(OFS_STAT);
         if (rv[3] === 1'h0)
            return;
         nb++;
      end
      n_errors++;
      $display("mismatch %0t poll never answered", $time);
      complete_run();
   endtask

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_read;
      reg_rd(OFS_STAT);
      chk(rv, 32'h00000000);
      reg_rd(5'h10);
      chk(rv, 32'h00000000);
      rd_chk(CMD_RAND, 10'h3FF, 2);
      rd_chk(CMD_CUR, 10'h001, 1);
   endtask

   // strobes taken while the clock enable is low must change nothing
   task automatic t_freeze;
      ce <= 1'h0;
      reg_wr(OFS_CTRL, ctl(CMD_POLL, 10'h000, 1, 1'h1));
      reg_wr(OFS_TXD, 32'h000000AB);
      ce <= 1'h1;
      reg_rd(OFS_STAT);
      chk(rv, 32'h00000000);
      reg_rd(OFS_TXD);
      chk(rv, 32'h00000000);
   endtask

   task automatic t_byte;
      do_wr(10'h234, 1, 8'hA5, 1'h1);
      emem[10'h234] = 8'hA5;
      reg_rd(OFS_STAT);
      chk(rv, 32'h00000000);
      poll();
      chk(32'(nb > 0), 32'h00000001);
      rd_chk(CMD_RAND, 10'h234, 1);
      rd_chk(CMD_CUR, 10'h235, 1);
   endtask

   task automatic t_page;
      do_wr(10'h14E, 16, 8'h10, 1'h1);
      for (int i = 0; i < 16; i++)
         emem[{6'h14, 4'(14 + i)}] = 8'h10 + 8'(i);
      poll();
      rd_chk(CMD_RAND, 10'h140, 16);
   endtask

   task automatic t_prot;
      wp <= 1'h1;
      do_wr(10'h320, 1, 8'h77, 1'h1);
      reg_rd(OFS_STAT);
      chk(rv, 32'h00000008);
      poll();
      chk(32'(nb), 32'h00000000);
      rd_chk(CMD_RAND, 10'h320, 1);
      do_wr(10'h005, 1, 8'h5C, 1'h1);
      emem[10'h005] = 8'h5C;
      poll();
      rd_chk(CMD_RAND, 10'h005, 1);
      wp <= 1'h0;
   endtask

   task automatic t_strap;
      do_wr(10'h000, 1, 8'h11, 1'h0);
      reg_rd(OFS_STAT);
      chk(32'(rv[3]), 32'h00000001);
      rd_chk(CMD_RAND, 10'h000, 1);
   endtask

   // ----------------------------------------------------------------
   // clock and main sequence
   // ----------------------------------------------------------------
   initial
   begin
      clock = 1'h0;
      forever
         #12.5 clock = ~clock;
   end

   initial
   begin
      {srst, wr, rd, wp, addr, wdata} = '0;
      srst = 1'h1;
      ce = 1'h1;
      n_errors = 0;
      cmp_count = 0;
      for (int i = 0; i < 1024; i++)
         emem[i] = 8'(i * 3 + 1);
      repeat (5) @(posedge clock);
      srst <= 1'h0;
      t_freeze();
      t_read();
      t_byte();
      t_page();
      t_prot();
      t_strap();
      complete_run();
   end
endmodule
